/* File: sec_ctrl.sv */
// Serial EEPROM command controller with APB register access and station address load.
// Assumes APB master on REF_CLK; EEDI arrives from the EEPROM pin asynchronously.
`timescale 1ns/100ps
module sec_ctrl #(
   parameter int TIMEOUT_CYC = sec_pkg::TIMEOUT_CYC,
   parameter logic [7:0] SIG = sec_pkg::SIG_BYTE
)(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Serial EEPROM pins
   output logic EECS,
   output logic EECLK,
   output logic EEDO,
   input wire logic EEDI,
   // Loaded station address
   output logic [47:0] MAC_ADDR,
   output logic MAC_VALID
);
   sec_pkg::sec_state_t state_q, state_d;
   sec_pkg::sec_cmd_t cmd_q, cmd_d;
   logic [7:0] data_q, data_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic cs_q, cs_d, sclk_q, sclk_d, do_q, do_d;
   logic [sec_pkg::FRAME_W-1:0] frame_q, frame_d;
   logic [4:0] nbits_q, nbits_d;
   logic [7:0] rx_q, rx_d;
   logic [7:0] div_q, div_d;
   logic [19:0] tmr_q, tmr_d;
   logic load_q, load_d;
   logic [2:0] idx_q, idx_d;
   logic [47:0] mac_q, mac_d;
   logic mac_valid_q, mac_valid_d;
   logic di_m, di_s;
   logic tick, wr, finish;

   // Serial frame for an operation, MSB first, left aligned
   function automatic logic [sec_pkg::FRAME_W-1:0] frame_of(logic [2:0] op,
      logic [sec_pkg::ADDR_W-1:0] addr, logic [7:0] data);
      logic [sec_pkg::FRAME_W-1:0] f;
      f = '0;
      if (op == sec_pkg::OP_READ)
      begin
         f = {1'b1, 2'h2, addr, 8'h00};
      end
      else if (op == sec_pkg::OP_WRITE)
      begin
         f = {1'b1, 2'h1, addr, data};
      end
      else if (op == sec_pkg::OP_EWEN)
      begin
         f = {1'b1, 2'h0, 7'h60, 8'h00};
      end
      else
      begin
         f = {1'b1, 2'h0, 7'h00, 8'h00};
      end
      return f;
   endfunction

   // Frame length for an operation
   function automatic logic [4:0] bits_of(logic [2:0] op);
      logic [4:0] n;
      n = sec_pkg::SHORT_BITS;
      if (op == sec_pkg::OP_READ || op == sec_pkg::OP_WRITE)
      begin
         n = sec_pkg::LONG_BITS;
      end
      return n;
   endfunction

   // Two-stage synchroniser for the EEPROM data pin
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         di_m <= 1'b0;
         di_s <= 1'b0;
      end
      else
      begin
         di_m <= EEDI;
         di_s <= di_m;
      end
   end

   // Next-state logic for bus, command register and serial engine
   always_comb
   begin
      state_d = state_q;
      cmd_d = cmd_q;
      data_d = data_q;
      cs_d = cs_q;
      sclk_d = sclk_q;
      do_d = do_q;
      frame_d = frame_q;
      nbits_d = nbits_q;
      rx_d = rx_q;
      tmr_d = tmr_q;
      load_d = load_q;
      idx_d = idx_q;
      mac_d = mac_q;
      mac_valid_d = mac_valid_q;
      finish = 1'b0;
      // Divider gives one-cycle serial half-period enable
      tick = (div_q == 8'(sec_pkg::SCLK_HALF_CYC - 1));
      div_d = tick ? 8'h00 : div_q + 8'h01;
      // APB: answer registered one cycle after setup
      pready_d = PSEL & ~PENABLE;
      prdata_d = 32'h0;
      pslverr_d = 1'b0;
      if (PSEL && !PENABLE)
      begin
         if (PADDR == sec_pkg::CMD_OFS)
         begin
            prdata_d = {cmd_q.busy, cmd_q.op, 21'h0, cmd_q.addr};
         end
         else if (PADDR == sec_pkg::DATA_OFS)
         begin
            prdata_d = {24'h0, data_q};
         end
         else
         begin
            pslverr_d = 1'b1;
         end
      end
      wr = PSEL & PENABLE & pready_q & PWRITE;
      // Command and data are locked while busy; zero to busy is ignored
      if (wr && PADDR == sec_pkg::CMD_OFS && !cmd_q.busy)
      begin
         cmd_d.op = PWDATA[sec_pkg::OP_LSB +: 3];
         cmd_d.addr = PWDATA[sec_pkg::ADDR_LSB +: sec_pkg::ADDR_W];
         cmd_d.busy = PWDATA[sec_pkg::BUSY_BIT];
      end
      if (wr && PADDR == sec_pkg::DATA_OFS && !cmd_q.busy)
      begin
         data_d = PWDATA[7:0];
      end
      // Serial engine
      case (state_q)
         sec_pkg::ST_IDLE:
         begin
            if (load_q)
            begin
               frame_d = frame_of(sec_pkg::OP_READ, {4'h0, idx_q}, 8'h00);
               nbits_d = sec_pkg::LONG_BITS;
               state_d = sec_pkg::ST_SHIFT;
               cs_d = 1'b1;
               do_d = 1'b1;
            end
            else if (cmd_q.busy && cmd_q.op <= sec_pkg::OP_WRITE)
            begin
               frame_d = frame_of(cmd_q.op, cmd_q.addr, data_q);
               nbits_d = bits_of(cmd_q.op);
               state_d = sec_pkg::ST_SHIFT;
               cs_d = 1'b1;
               do_d = 1'b1;
            end
            else if (cmd_q.busy)
            begin
               cmd_d.busy = 1'b0; // Unused codes complete at once
            end
         end
         sec_pkg::ST_SHIFT:
         begin
            if (tick && !sclk_q)
            begin
               sclk_d = 1'b1;
            end
            else if (tick)
            begin
               sclk_d = 1'b0;
               rx_d = {rx_q[6:0], di_s};
               frame_d = {frame_q[sec_pkg::FRAME_W-2:0], 1'b0};
               do_d = frame_q[sec_pkg::FRAME_W-2];
               nbits_d = nbits_q - 5'h01;
               if (nbits_q == 5'h01)
               begin
                  state_d = sec_pkg::ST_GAP;
                  cs_d = 1'b0;
                  do_d = 1'b0;
               end
            end
         end
         sec_pkg::ST_GAP:
         begin
            if (tick && cmd_q.op == sec_pkg::OP_WRITE && !load_q)
            begin
               state_d = sec_pkg::ST_WAIT;
               cs_d = 1'b1;
               tmr_d = 20'h0;
            end
            else if (tick)
            begin
               finish = 1'b1;
            end
         end
         default:
         begin
            // Ready polling; a missing EEPROM never answers
            tmr_d = tmr_q + 20'h1;
            if (di_s || tmr_q == 20'(TIMEOUT_CYC - 1))
            begin
               cs_d = 1'b0;
               finish = 1'b1;
            end
         end
      endcase
      // Completion of an operation
      if (finish)
      begin
         state_d = sec_pkg::ST_IDLE;
         if (load_q && idx_q == 3'h0 && rx_q != SIG)
         begin
            load_d = 1'b0;
            cmd_d.busy = 1'b0;
         end
         else if (load_q)
         begin
            if (idx_q != 3'h0)
            begin
               mac_d[8*(int'(idx_q)-1) +: 8] = rx_q;
            end
            idx_d = idx_q + 3'h1;
            if (idx_q == 3'(sec_pkg::MAC_BYTES))
            begin
               load_d = 1'b0;
               cmd_d.busy = 1'b0;
               mac_valid_d = 1'b1;
            end
         end
         else
         begin
            cmd_d.busy = 1'b0;
            if (cmd_q.op == sec_pkg::OP_READ)
            begin
               data_d = rx_q;
            end
         end
      end
   end

   // State registers
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         state_q <= sec_pkg::ST_IDLE;
         cmd_q <= '{busy: sec_pkg::CMD_BUSY_RST, op: sec_pkg::CMD_OP_RST, addr: '0};
         data_q <= sec_pkg::DATA_RST;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         cs_q <= 1'b0;
         sclk_q <= 1'b0;
         do_q <= 1'b0;
         frame_q <= '0;
         nbits_q <= 5'h0;
         rx_q <= 8'h0;
         div_q <= 8'h0;
         tmr_q <= 20'h0;
         load_q <= 1'b1;
         idx_q <= 3'h0;
         mac_q <= 48'h0;
         mac_valid_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         data_q <= data_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         cs_q <= cs_d;
         sclk_q <= sclk_d;
         do_q <= do_d;
         frame_q <= frame_d;
         nbits_q <= nbits_d;
         rx_q <= rx_d;
         div_q <= div_d;
         tmr_q <= tmr_d;
         load_q <= load_d;
         idx_q <= idx_d;
         mac_q <= mac_d;
         mac_valid_q <= mac_valid_d;
      end
   end

   // Outputs straight from registers
   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign EECS = cs_q;
   assign EECLK = sclk_q;
   assign EEDO = do_q;
   assign MAC_ADDR = mac_q;
   assign MAC_VALID = mac_valid_q;

   // Checks
   busy_after_reset_a: assert property (@(posedge REF_CLK) $fell(RESET) |-> cmd_q.busy && load_q)
      else $error("busy not high after reset");
   cmd_start_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (state_q == sec_pkg::ST_IDLE && !load_q && cmd_q.busy && cmd_q.op <= sec_pkg::OP_WRITE)
      |=> state_q == sec_pkg::ST_SHIFT && EECS)
      else $error("command did not start");
   busy_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      state_q != sec_pkg::ST_IDLE |-> cmd_q.busy)
      else $error("busy dropped during operation");
   read_data_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      ($fell(cmd_q.busy) && cmd_q.op == sec_pkg::OP_READ && !$past(load_q))
      |-> data_q == $past(rx_q))
      else $error("read data not loaded at busy clear");
   write_timeout_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (state_q == sec_pkg::ST_WAIT && tmr_q == 20'(TIMEOUT_CYC - 1)) |=> !cmd_q.busy)
      else $error("busy not cleared at time-out");
   zero_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (wr && PADDR == sec_pkg::CMD_OFS && !PWDATA[31] && cmd_q.busy && !finish
      && !(state_q == sec_pkg::ST_IDLE && !load_q && cmd_q.op > sec_pkg::OP_WRITE))
      |=> cmd_q.busy && $stable(cmd_q.op))
      else $error("busy changed by a zero write");
   load_end_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      $fell(load_q) |-> !cmd_q.busy)
      else $error("busy still set after address load");
   cs_gap_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      state_q == sec_pkg::ST_GAP |-> !EECS && !EECLK)
      else $error("chip select high in gap");
endmodule // sec_ctrl

/* File: sec_eeprom_model.sv */
// Behavioural serial EEPROM of 128 bytes on the three-wire link.
// Assumes a pull-down on the data line, so an absent part reads low.
`timescale 1ns/100ps
module sec_eeprom_model #(
   parameter logic [7:0] SIG = sec_pkg::SIG_BYTE
)(
   // Link pins
   input wire logic EECS,
   input wire logic EECLK,
   input wire logic EEDO,
   output logic EEDI,
   // Part fitted
   input wire logic PRESENT
);
   int rcnt = 0;
   logic [8:0] hdr = 9'h000;
   logic [7:0] byt;
   logic dq = 1'b0;
   // Address and data of the last write frame, for the bench
   logic [7:0] wdat = 8'h00;
   logic [6:0] wadr = 7'h00;
   // Frame bit counter restarts with each select
   always @(posedge EECS) rcnt = 0;
   // Released line shows the inverse of its last bit
   always @(negedge EECS) dq = ~dq;
   // Take opcode and address, then shift out the addressed byte
   always @(posedge EECLK)
   begin
      if (EECS)
      begin
         rcnt = rcnt + 1;
         if (rcnt >= 2 && rcnt <= 10) hdr = {hdr[7:0], EEDO};
         byt = (hdr[6:0] == 7'h00) ? SIG : 8'({1'b0, hdr[6:0]} * 8'h1d + 8'h03);
         if (rcnt >= 11 && rcnt <= 18) dq = byt[18-rcnt];
         if (rcnt >= 11 && rcnt <= 18 && hdr[8:7] == 2'b01) wdat = {wdat[6:0], EEDO};
         if (rcnt == 18 && hdr[8:7] == 2'b01) wadr = hdr[6:0];
      end
   end
   // Ready at once when selected without clocks; absent part reads low
   assign EEDI = !PRESENT ? 1'b0 : (EECS && rcnt == 0) ? 1'b1 : dq;
endmodule // sec_eeprom_model

/* File: sec_pkg.sv */
// Constants, types and register layout for the serial EEPROM command block.
// Assumes a 25 MHz reference clock and a three-wire serial EEPROM with 8-bit words.
// Summary of operation
// - Setting busy starts the selected EEPROM operation
// - Busy stays set until the operation completes
// - Read data is valid when busy clears
// - Write without EEPROM clears busy at time-out
// - Busy reads high right after reset
// - Station address loads after reset when the signature byte matches, then busy clears
package sec_pkg;
   // Register byte offsets
   localparam logic [7:0] CMD_OFS = 8'hb0;
   localparam logic [7:0] DATA_OFS = 8'hb4;
   // Field positions in the command register
   localparam int BUSY_BIT = 31;
   localparam int OP_LSB = 28;
   localparam int ADDR_LSB = 0;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   // Command codes
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_EWDS = 3'h1;
   localparam logic [2:0] OP_EWEN = 3'h2;
   localparam logic [2:0] OP_WRITE = 3'h3;
   // Serial frame sizes in bits
   localparam int FRAME_W = 18;
   localparam logic [4:0] LONG_BITS = 5'h12;
   localparam logic [4:0] SHORT_BITS = 5'h0a;
   // Timing
   localparam int REF_CLK_KHZ = 25000;
   localparam int SCLK_HALF_NS = 200;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * REF_CLK_KHZ) / 1000000;
   localparam int TIMEOUT_MS = 30;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * REF_CLK_KHZ;
   // Station address load
   localparam int MAC_BYTES = 6;
   localparam logic [7:0] SIG_BYTE = 8'ha5; // Arbitrary signature value
   // Reset values
   localparam logic CMD_BUSY_RST = 1'b1;
   localparam logic [2:0] CMD_OP_RST = 3'h0;
   localparam logic [7:0] DATA_RST = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SHIFT = 2'h1,
      ST_GAP = 2'h3,
      ST_WAIT = 2'h2
   } sec_state_t;

   typedef struct packed {
      logic busy;
      logic [2:0] op;
      logic [ADDR_W-1:0] addr;
   } sec_cmd_t;
endpackage

/* File: test_serial_eeprom_command_control.sv */
// Self-checking bench for the serial EEPROM command block over APB.
// Assumes the partner model sec_eeprom_model and a short time-out.
`timescale 1ns/100ps
module test_serial_eeprom_command_control;
   localparam int TMO = 50;
   logic REF_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic EECS, EECLK, EEDO, EEDI, MAC_VALID, PRESENT;
   logic [7:0] PADDR;
   logic [6:0] a;
   logic [7:0] w;
   logic [31:0] PWDATA, PRDATA, d;
   logic [47:0] MAC_ADDR;
   logic [65:0] notes[$];
   logic [65:0] nt;
   int failures = 0;
   int checks_done = 0;
   int cyc = 0;
   int t0;
   sec_ctrl #(.TIMEOUT_CYC(TMO)) u_dut (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .EECS(EECS), .EECLK(EECLK), .EEDO(EEDO),
      .EEDI(EEDI), .MAC_ADDR(MAC_ADDR), .MAC_VALID(MAC_VALID));
   sec_eeprom_model u_rom (.EECS(EECS), .EECLK(EECLK), .EEDO(EEDO), .EEDI(EEDI),
      .PRESENT(PRESENT));
   // Expected contents of the part
   function automatic logic [7:0] rom_byte(input logic [6:0] x);
      return (x == 7'h00) ? sec_pkg::SIG_BYTE : 8'({1'b0, x} * 8'h1d + 8'h03);
   endfunction
   // Clock and cycle count
   initial
   begin
      REF_CLK = 1'b0;
      forever #20 REF_CLK = ~REF_CLK;
   end
   always @(posedge REF_CLK) cyc <= cyc + 1;
   // Verdict and end of run
   task automatic wrap_up;
      if (failures == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer, read data taken at the pready edge
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= wd;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do
      begin
         @(posedge REF_CLK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 20);
      d = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (PREADY !== 1'b1)
      begin
         failures++;
         wrap_up();
      end
      @(posedge REF_CLK);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [32:0] exp, input logic [32:0] m);
      notes.push_back({m, exp});
      apb(1'b0, ad, 32'h0);
   endtask
   task automatic poll;
      int n;
      n = 0;
      do
      begin
         rd(sec_pkg::CMD_OFS, 33'h0, 33'h0);
         n++;
      end
      while (d[31] !== 1'b0 && n < 3000);
      if (d[31] !== 1'b0)
      begin
         failures++;
         wrap_up();
      end
   endtask
   // Compare each read answer with the oldest note
   always @(posedge REF_CLK)
   begin
      if (PSEL && PENABLE && PREADY === 1'b1 && PWRITE === 1'b0)
      begin
         nt = notes.pop_front();
         checks_done++;
         if (({PSLVERR, PRDATA} & nt[65:33]) !== (nt[32:0] & nt[65:33]))
         begin
            failures++;
            $display("FAIL t=%0t got %h exp %h", $time, {PSLVERR, PRDATA}, nt[32:0]);
         end
      end
   end
   // Main sequence
   initial
   begin
      RESET = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      PRESENT = 1'b1;
      void'($urandom(32'h1aee7f56));
      repeat (2) @(posedge REF_CLK);
      RESET <= 1'b0;
      @(posedge REF_CLK);
      rd(sec_pkg::CMD_OFS, 33'h0_8000_0000, 33'h1_8000_0000);
      poll();
      chk({47'h0, MAC_VALID}, 48'h1);
      chk(MAC_ADDR, {rom_byte(7'h6), rom_byte(7'h5), rom_byte(7'h4), rom_byte(7'h3),
         rom_byte(7'h2), rom_byte(7'h1)});
      rd(8'h40, {1'b1, 32'h0}, {33{1'b1}});
      // Reads at random addresses, with a zero write to busy mid-way
      repeat (4)
      begin
         a = 7'($urandom);
         apb(1'b1, sec_pkg::CMD_OFS, {1'b1, sec_pkg::OP_READ, 21'h0, a});
         apb(1'b1, sec_pkg::CMD_OFS, {1'b0, 3'h7, 21'h0, 7'h7f});
         rd(sec_pkg::CMD_OFS, {2'b01, sec_pkg::OP_READ, 21'h0, a}, 33'h1_f000_007f);
         poll();
         rd(sec_pkg::DATA_OFS, {25'h0, rom_byte(a)}, {33{1'b1}});
      end
      // Every command code runs and finishes
      for (int op = 0; op < 8; op++)
      begin
         if (op == 3)
         begin
            w = 8'($urandom);
            apb(1'b1, sec_pkg::DATA_OFS, {24'h0, w});
         end
         apb(1'b1, sec_pkg::CMD_OFS, {1'b1, 3'(op), 21'h0, 7'h55});
         if (op == 3)
         begin
            apb(1'b1, sec_pkg::DATA_OFS, {24'h0, ~w});
            rd(sec_pkg::DATA_OFS, {25'h0, w}, {33{1'b1}});
         end
         poll();
         rd(sec_pkg::CMD_OFS, {2'b00, 3'(op), 21'h0, 7'h55}, 33'h1_f000_007f);
      end
      // The write frame carried the chosen address and the data register byte
      chk({41'h0, u_rom.wadr}, 48'h55);
      chk({40'h0, u_rom.wdat}, {40'h0, w});
      // Write with no part fitted ends at the time-out
      PRESENT <= 1'b0;
      apb(1'b1, sec_pkg::CMD_OFS, {1'b1, sec_pkg::OP_WRITE, 21'h0, 7'h12});
      t0 = cyc;
      poll();
      chk({47'h0, (cyc - t0 >= TMO + 150)}, 48'h1);
      chk({47'h0, (cyc - t0 < TMO + 400)}, 48'h1);
      // Reset again with no part fitted: the load is only attempted
      RESET <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      RESET <= 1'b0;
      @(posedge REF_CLK);
      rd(sec_pkg::CMD_OFS, 33'h0_8000_0000, 33'h1_8000_0000);
      poll();
      chk({47'h0, MAC_VALID}, 48'h0);
      chk(MAC_ADDR, 48'h0);
      wrap_up();
   end
endmodule // test_serial_eeprom_command_control
